/* hdl/pmtsc_pkg.sv */
package pmtsc_pkg;

    // register map
    localparam logic [7:0] STAT_ADDR = 8'h01;
    localparam logic [7:0] MSEL_ADDR = 8'h03;
    localparam logic [7:0] CTRL_ADDR = 8'h04;
    localparam logic [7:0] FEAT_ADDR = 8'h07;
    localparam logic [7:0] WREN_ADDR = 8'h08;

    // field positions
    localparam int SLEEP_BIT    = 7;
    localparam int AUTO_OFF_BIT = 7;
    localparam int FORCE_BIT    = 5;
    localparam int WAKE_POL_BIT = 0;
    localparam int UNLOCK_BIT   = 7;
    localparam int FLAG_HI_BIT  = 4;
    localparam int FLAG_LO_BIT  = 3;
    localparam int ST_OVT_BIT   = 0;
    localparam int ST_SUP_BIT   = 1;
    localparam int ST_SET_BIT   = 2;
    localparam int ST_AWAKE_BIT = 3;
    localparam int MSEL_W       = 4;

    // values after reset
    localparam logic             SLEEP_RST    = 1'b0;
    localparam logic             AUTO_OFF_RST = 1'b0;
    localparam logic             FORCE_RST    = 1'b0;
    localparam logic             WAKE_POL_RST = 1'b0;
    localparam logic             UNLOCK_RST   = 1'b0;
    localparam logic             FLAG_RST     = 1'b0;
    localparam logic [MSEL_W-1:0] MSEL_RST    = 4'h0;

    // monitor select codes
    localparam logic [MSEL_W-1:0] MSEL_NONE  = 4'h0;
    localparam logic [MSEL_W-1:0] MSEL_CELL1 = 4'h1;
    localparam logic [MSEL_W-1:0] MSEL_CELL7 = 4'h7;
    localparam logic [MSEL_W-1:0] MSEL_EXT   = 4'h8;
    localparam logic [MSEL_W-1:0] MSEL_INT   = 4'h9;

    // timing
    localparam int unsigned CLK_KHZ        = 200000;
    localparam int unsigned SCAN_PERIOD_MS = 640;
    localparam int unsigned SCAN_ON_MS     = 5;
    localparam int unsigned SETTLE_MS      = 1;
    localparam int unsigned SCAN_PERIOD_CYC = SCAN_PERIOD_MS * CLK_KHZ;
    localparam int unsigned SCAN_ON_CYC     = SCAN_ON_MS * CLK_KHZ;
    localparam int unsigned SETTLE_CYC      = SETTLE_MS * CLK_KHZ;

    typedef enum logic [1:0] {
        PWR_OFF    = 2'b00,
        PWR_AWAKE  = 2'b01,
        PWR_ASLEEP = 2'b10
    } pmtsc_pwr_t;

endpackage : pmtsc_pkg

/* hdl/pmtsc_scan_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pmtsc_scan_if;
    logic auto_en;
    logic sel_ext;
    logic force_on;
    logic below_ref;
    logic supply_on;
    logic settled;
    logic overtemp;

    modport ctrl (output auto_en, output sel_ext, output force_on, output below_ref,
                  input supply_on, input settled, input overtemp);
    modport seq  (input auto_en, input sel_ext, input force_on, input below_ref,
                  output supply_on, output settled, output overtemp);
endinterface : pmtsc_scan_if
`default_nettype wire

/* hdl/pmtsc_scan_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module pmtsc_scan_seq #(
    parameter int unsigned PERIOD_CYC = pmtsc_pkg::SCAN_PERIOD_CYC,
    parameter int unsigned ON_CYC     = pmtsc_pkg::SCAN_ON_CYC,
    parameter int unsigned SETTLE_CYC = pmtsc_pkg::SETTLE_CYC
) (
    // clock and reset
    input  wire logic      clk_sys,
    input  wire logic      rst_n,
    // control side
    pmtsc_scan_if.seq      scan
);

    logic [31:0] period_cnt_ff;
    logic [31:0] settle_cnt_ff;
    logic        supply_on_ff;
    logic        overtemp_ff;
    logic        auto_on;
    logic        settled;

    // free-running time base; the automatic window is a slice of it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            period_cnt_ff <= 32'h0;
        end else if (period_cnt_ff >= PERIOD_CYC - 1) begin
            period_cnt_ff <= 32'h0;
        end else begin
            period_cnt_ff <= period_cnt_ff + 32'h1;
        end
    end

    assign auto_on = scan.auto_en && (period_cnt_ff < ON_CYC);

    // force and manual selection simply or in, so they never disturb each other
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            supply_on_ff <= 1'b0;
        end else begin
            supply_on_ff <= scan.force_on | scan.sel_ext | auto_on;
        end
    end

    // settling restarts each time the supply turns on
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            settle_cnt_ff <= 32'h0;
        end else if (!supply_on_ff) begin
            settle_cnt_ff <= 32'h0;
        end else if (settle_cnt_ff != SETTLE_CYC) begin
            settle_cnt_ff <= settle_cnt_ff + 32'h1;
        end
    end

    assign settled = supply_on_ff && (settle_cnt_ff == SETTLE_CYC);

    // verdict held between scans so software sees the last result
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            overtemp_ff <= 1'b0;
        end else if (settled) begin
            overtemp_ff <= scan.below_ref;
        end
    end

    assign scan.supply_on = supply_on_ff;
    assign scan.settled   = settled;
    assign scan.overtemp  = overtemp_ff;

endmodule : pmtsc_scan_seq
`default_nettype wire

/* hdl/pmtsc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pmtsc_top #(
    parameter int unsigned SCAN_PERIOD_CYC = pmtsc_pkg::SCAN_PERIOD_CYC,
    parameter int unsigned SCAN_ON_CYC     = pmtsc_pkg::SCAN_ON_CYC,
    parameter int unsigned SETTLE_CYC      = pmtsc_pkg::SETTLE_CYC
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // register port from the serial host link
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // supply comparators
    input  wire logic [2:0] por_ok_taps,
    input  wire logic       por_ok_vcc,
    // wake and temperature inputs
    input  wire logic       wake_pin,
    input  wire logic       thermistor_below_ref,
    // power and sensor outputs
    output logic            regulated_supply_out,
    output logic            sensor_supply_out,
    output logic            ext_overtemp,
    // analog monitor multiplexer
    output logic      [3:0] monitor_route,
    output logic            monitor_low_power,
    output logic            route_thermistor
);

    pmtsc_pkg::pmtsc_pwr_t pwr_ff;
    pmtsc_pkg::pmtsc_pwr_t nxt_pwr;

    logic                           sleep_ff;
    logic                           auto_off_ff;
    logic                           force_ff;
    logic                           wake_pol_ff;
    logic                           unlock_ff;
    logic                           flag_hi_ff;
    logic                           flag_lo_ff;
    logic [pmtsc_pkg::MSEL_W-1:0]   msel_ff;
    logic                           wake_prev_ff;
    logic                           rso_ff;
    logic [3:0]                     route_ff;
    logic [7:0]                     rdata_ff;
    logic [7:0]                     nxt_rdata;
    logic                           por_all;
    logic                           awake;
    logic                           wake_edge;
    logic                           wr_ctrl;
    logic                           wr_feat;
    logic                           wr_wren;
    logic                           wr_msel;
    logic                           sleep_set;
    logic                           wake_now;

    pmtsc_scan_if scan ();

    // reserved codes fall back to the low-power "no output" state
    function automatic logic [3:0] mon_route(input logic [3:0] code);
        logic [3:0] r;
        r = pmtsc_pkg::MSEL_NONE;
        if (code >= pmtsc_pkg::MSEL_CELL1 && code <= pmtsc_pkg::MSEL_CELL7) begin
            r = code;
        end else if (code == pmtsc_pkg::MSEL_EXT || code == pmtsc_pkg::MSEL_INT) begin
            r = code;
        end
        return r;
    endfunction : mon_route

    // one address compare shared by write decode and readback
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_off);
        return addr == reg_off;
    endfunction : hit

    assign wr_ctrl = reg_wr && hit(reg_addr, pmtsc_pkg::CTRL_ADDR);
    assign wr_feat = reg_wr && hit(reg_addr, pmtsc_pkg::FEAT_ADDR);
    assign wr_wren = reg_wr && hit(reg_addr, pmtsc_pkg::WREN_ADDR);
    assign wr_msel = reg_wr && hit(reg_addr, pmtsc_pkg::MSEL_ADDR);

    // any tap or the main supply under threshold drops power
    assign por_all = (&por_ok_taps) && por_ok_vcc;
    assign awake   = (pwr_ff == pmtsc_pkg::PWR_AWAKE);

    // power-state sequencing

    // pin is already synchronous; one flop of history gives the edge
    // history resets low, so a pin held low never looks like a fresh fall
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wake_prev_ff <= 1'b0;
        end else begin
            wake_prev_ff <= wake_pin;
        end
    end

    assign wake_edge = wake_pol_ff ? (wake_pin && !wake_prev_ff)
                                   : (!wake_pin && wake_prev_ff);

    always_comb begin
        nxt_pwr = pwr_ff;
        unique case (pwr_ff)
            pmtsc_pkg::PWR_OFF: begin
                if (por_all) begin
                    nxt_pwr = pmtsc_pkg::PWR_AWAKE;
                end
            end
            pmtsc_pkg::PWR_AWAKE: begin
                if (!por_all) begin
                    nxt_pwr = pmtsc_pkg::PWR_OFF;
                end else if (sleep_ff) begin
                    nxt_pwr = pmtsc_pkg::PWR_ASLEEP;
                end
            end
            pmtsc_pkg::PWR_ASLEEP: begin
                if (!por_all) begin
                    nxt_pwr = pmtsc_pkg::PWR_OFF;
                end else if (wake_edge) begin
                    nxt_pwr = pmtsc_pkg::PWR_AWAKE;
                end
            end
            default: begin
                // 2'b11 is unused; fall back to the power-on state
                nxt_pwr = pmtsc_pkg::PWR_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pwr_ff <= pmtsc_pkg::PWR_OFF;
        end else begin
            pwr_ff <= nxt_pwr;
        end
    end

    // regulator follows the next state so it changes with the state itself
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rso_ff <= 1'b0;
        end else begin
            rso_ff <= (nxt_pwr == pmtsc_pkg::PWR_AWAKE);
        end
    end

    assign regulated_supply_out = rso_ff;

    // force-sleep bit

    assign sleep_set = wr_ctrl && reg_wdata[pmtsc_pkg::SLEEP_BIT];
    assign wake_now  = (pwr_ff == pmtsc_pkg::PWR_ASLEEP) && (nxt_pwr == pmtsc_pkg::PWR_AWAKE);

    // a fresh request wins over the self-clear in the same cycle
    // clearing while off stops a stale request from sleeping the next power-up
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sleep_ff <= pmtsc_pkg::SLEEP_RST;
        end else if (sleep_set) begin
            sleep_ff <= 1'b1;
        end else if (wake_now || pwr_ff == pmtsc_pkg::PWR_OFF) begin
            sleep_ff <= 1'b0;
        end
    end

    // feature configuration, write-protected

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            auto_off_ff <= pmtsc_pkg::AUTO_OFF_RST;
            force_ff    <= pmtsc_pkg::FORCE_RST;
            wake_pol_ff <= pmtsc_pkg::WAKE_POL_RST;
        end else if (wr_feat && unlock_ff) begin
            auto_off_ff <= reg_wdata[pmtsc_pkg::AUTO_OFF_BIT];
            force_ff    <= reg_wdata[pmtsc_pkg::FORCE_BIT];
            wake_pol_ff <= reg_wdata[pmtsc_pkg::WAKE_POL_BIT];
        end
    end

    // write enable and spare flags

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            unlock_ff <= pmtsc_pkg::UNLOCK_RST;
        end else if (wr_wren) begin
            unlock_ff <= reg_wdata[pmtsc_pkg::UNLOCK_BIT];
        end
    end

    // only a true power-on reset clears these; sleep leaves them alone
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_hi_ff <= pmtsc_pkg::FLAG_RST;
            flag_lo_ff <= pmtsc_pkg::FLAG_RST;
        end else if (wr_wren) begin
            flag_hi_ff <= reg_wdata[pmtsc_pkg::FLAG_HI_BIT];
            flag_lo_ff <= reg_wdata[pmtsc_pkg::FLAG_LO_BIT];
        end
    end

    // monitor selection

    // kept through sleep so the choice survives a wake cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            msel_ff <= pmtsc_pkg::MSEL_RST;
        end else if (wr_msel) begin
            msel_ff <= reg_wdata[pmtsc_pkg::MSEL_W-1:0];
        end
    end

    // multiplexer goes dark one cycle after the regulator turns off
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            route_ff <= pmtsc_pkg::MSEL_NONE;
        end else if (awake) begin
            route_ff <= mon_route(msel_ff);
        end else begin
            route_ff <= pmtsc_pkg::MSEL_NONE;
        end
    end

    assign monitor_route     = route_ff;
    assign monitor_low_power = (route_ff == pmtsc_pkg::MSEL_NONE);
    assign route_thermistor  = (route_ff == pmtsc_pkg::MSEL_EXT);

    // temperature scan

    assign scan.auto_en   = awake && !auto_off_ff;
    // gated by awake so a held selection cannot run the sensor while asleep
    assign scan.sel_ext   = awake && route_thermistor;
    assign scan.force_on  = awake && force_ff;
    assign scan.below_ref = thermistor_below_ref;

    pmtsc_scan_seq #(
        .PERIOD_CYC (SCAN_PERIOD_CYC),
        .ON_CYC     (SCAN_ON_CYC),
        .SETTLE_CYC (SETTLE_CYC)
    ) u_scan (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .scan    (scan)
    );

    assign sensor_supply_out = scan.supply_on;
    assign ext_overtemp      = scan.overtemp;

    // register readback
    // reserved and unmapped bits read as zero

    always_comb begin
        nxt_rdata = 8'h00;
        if (hit(reg_addr, pmtsc_pkg::CTRL_ADDR)) begin
            nxt_rdata[pmtsc_pkg::SLEEP_BIT] = sleep_ff;
        end else if (hit(reg_addr, pmtsc_pkg::FEAT_ADDR)) begin
            nxt_rdata[pmtsc_pkg::AUTO_OFF_BIT] = auto_off_ff;
            nxt_rdata[pmtsc_pkg::FORCE_BIT]    = force_ff;
            nxt_rdata[pmtsc_pkg::WAKE_POL_BIT] = wake_pol_ff;
        end else if (hit(reg_addr, pmtsc_pkg::WREN_ADDR)) begin
            nxt_rdata[pmtsc_pkg::UNLOCK_BIT]  = unlock_ff;
            nxt_rdata[pmtsc_pkg::FLAG_HI_BIT] = flag_hi_ff;
            nxt_rdata[pmtsc_pkg::FLAG_LO_BIT] = flag_lo_ff;
        end else if (hit(reg_addr, pmtsc_pkg::MSEL_ADDR)) begin
            nxt_rdata[pmtsc_pkg::MSEL_W-1:0] = msel_ff;
        end else if (hit(reg_addr, pmtsc_pkg::STAT_ADDR)) begin
            nxt_rdata[pmtsc_pkg::ST_OVT_BIT]   = scan.overtemp;
            nxt_rdata[pmtsc_pkg::ST_SUP_BIT]   = scan.supply_on;
            nxt_rdata[pmtsc_pkg::ST_SET_BIT]   = scan.settled;
            nxt_rdata[pmtsc_pkg::ST_AWAKE_BIT] = awake;
        end
    end

    // data held until the next read strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

endmodule : pmtsc_top
`default_nettype wire

/* verif/pmtsc_checker_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module pmtsc_checker #(
    parameter int unsigned SETTLE_CYC = pmtsc_pkg::SETTLE_CYC
) (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // supplies, wake and thermistor
    input wire logic [2:0] por_ok_taps,
    input wire logic       por_ok_vcc,
    input wire logic       wake_pin,
    input wire logic       thermistor_below_ref,
    // block outputs
    input wire logic       regulated_supply_out,
    input wire logic       sensor_supply_out,
    input wire logic       ext_overtemp,
    input wire logic [3:0] monitor_route,
    input wire logic       monitor_low_power,
    input wire logic       route_thermistor
);
    logic [31:0] on_cnt_ff;
    logic        por_ok;

    assign por_ok = (&por_ok_taps) & por_ok_vcc;

    // consecutive cycles with the sensor supply on, saturating
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            on_cnt_ff <= 32'h0000_0000;
        end else if (!sensor_supply_out) begin
            on_cnt_ff <= 32'h0000_0000;
        end else if (on_cnt_ff != 32'hffff_ffff) begin
            on_cnt_ff <= on_cnt_ff + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_powerup_reg_on: assert property ($rose(rst_n) && por_ok |=> regulated_supply_out)
        else $error("regulator not on after power-up");
    a_por_loss_off: assert property (!por_ok |=> !regulated_supply_out)
        else $error("regulator on after supply loss");
    a_sleep_reg_off: assert property (reg_wr && reg_addr == pmtsc_pkg::CTRL_ADDR
        && reg_wdata[7] && regulated_supply_out && por_ok |-> ##2 !regulated_supply_out)
        else $error("regulator still on after sleep command");
    a_asleep_no_sensor: assert property (!regulated_supply_out && !$past(regulated_supply_out)
        |-> !sensor_supply_out)
        else $error("sensor supply on while regulator off");
    a_route_decode: assert property (monitor_low_power == (monitor_route == pmtsc_pkg::MSEL_NONE)
        && route_thermistor == (monitor_route == pmtsc_pkg::MSEL_EXT))
        else $error("monitor route flags disagree with code");
    a_ext_keeps_on: assert property (route_thermistor && $past(route_thermistor)
        && regulated_supply_out && $past(regulated_supply_out) |-> sensor_supply_out)
        else $error("sensor supply off while external selected");
    a_ovt_settled: assert property ($changed(ext_overtemp)
        |-> $past(on_cnt_ff) >= SETTLE_CYC)
        else $error("over-temperature verdict changed before settling");
    a_ovt_follow: assert property ($changed(ext_overtemp)
        |-> ext_overtemp == $past(thermistor_below_ref))
        else $error("over-temperature verdict not from comparator");
    a_wren_reserved: assert property (reg_rd && reg_addr == pmtsc_pkg::WREN_ADDR
        |=> (reg_rdata & 8'h67) == 8'h00)
        else $error("reserved write-enable bits not zero");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
endmodule : pmtsc_checker

bind pmtsc_top pmtsc_checker #(.SETTLE_CYC(SETTLE_CYC)) i_pmtsc_checker (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .por_ok_taps, .por_ok_vcc, .wake_pin, .thermistor_below_ref,
    .regulated_supply_out, .sensor_supply_out, .ext_overtemp,
    .monitor_route, .monitor_low_power, .route_thermistor);
`default_nettype wire

/* verif/pmtsc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pmtsc_host_model (
    // clock
    input  wire logic       clk_sys,
    // register port toward the device
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // single byte per transfer; released lines show the inverse, not stale data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
        reg_addr  <= ~a;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk_sys);
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : pmtsc_host_model
`default_nettype wire

/* verif/tb_pmtsc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_pmtsc_top;
    localparam int unsigned PER = 200;
    localparam int unsigned ON  = 20;
    localparam int unsigned SET = 5;

    logic       clk_sys;
    logic       rst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic [2:0] por_ok_taps;
    logic       por_ok_vcc;
    logic       wake_pin;
    logic       thermistor_below_ref;
    logic       regulated_supply_out;
    logic       sensor_supply_out;
    logic       ext_overtemp;
    logic [3:0] monitor_route;
    logic       monitor_low_power;
    logic       route_thermistor;
    int         fails;
    int         n_checks;
    int         cnt;
    logic [7:0] rv;
    logic [7:0] flags;
    logic       pol;

    pmtsc_top #(.SCAN_PERIOD_CYC(PER), .SCAN_ON_CYC(ON), .SETTLE_CYC(SET)) i_pmtsc_top (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .por_ok_taps(por_ok_taps),
        .por_ok_vcc(por_ok_vcc), .wake_pin(wake_pin),
        .thermistor_below_ref(thermistor_below_ref),
        .regulated_supply_out(regulated_supply_out), .sensor_supply_out(sensor_supply_out),
        .ext_overtemp(ext_overtemp), .monitor_route(monitor_route),
        .monitor_low_power(monitor_low_power), .route_thermistor(route_thermistor));

    pmtsc_host_model i_pmtsc_host_model (
        .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] auto_on(input int n);
        return 16'((n / PER) * ON);
    endfunction : auto_on

    function automatic logic [3:0] exp_route(input int c);
        return (c <= 9) ? 4'(c) : 4'h0;
    endfunction : exp_route

    task automatic check_eq(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check_eq

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic count_on(input int n);
        cnt = 0;
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            if (sensor_supply_out === 1'b1) cnt++;
        end
    endtask : count_on

    task automatic chk_rd(input string what, input logic [7:0] a, input logic [7:0] exp);
        i_pmtsc_host_model.rd(a, rv);
        check_eq(what, 16'(rv), 16'(exp));
    endtask : chk_rd

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        tally_and_finish();
    end

    initial begin
        rst_n = 1'b0;
        por_ok_taps = 3'h7;
        por_ok_vcc = 1'b1;
        wake_pin = 1'b1;
        thermistor_below_ref = 1'b0;
        fails = 0;
        n_checks = 0;
        void'($urandom(32'hde8dbe46));
        flags = 8'($urandom) & 8'h18;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        cyc(1);
        check_eq("reg_on", 16'(regulated_supply_out), 16'h1);
        chk_rd("wren_rst", pmtsc_pkg::WREN_ADDR, 8'h00);
        i_pmtsc_host_model.wr(pmtsc_pkg::FEAT_ADDR, 8'($urandom) | 8'h01);
        chk_rd("feat_locked", pmtsc_pkg::FEAT_ADDR, 8'h00);
        i_pmtsc_host_model.wr(pmtsc_pkg::WREN_ADDR, 8'h80 | flags);
        chk_rd("wren", pmtsc_pkg::WREN_ADDR, 8'h80 | flags);
        i_pmtsc_host_model.wr(8'h0e, 8'($urandom));
        chk_rd("unmapped", 8'h0e, 8'h00);
        // default automatic scan with the thermistor showing a fault
        @(posedge clk_sys);
        thermistor_below_ref <= 1'b1;
        count_on(2 * PER);
        check_eq("auto_on", 16'(cnt), auto_on(2 * PER));
        check_eq("ovt_set", 16'(ext_overtemp), 16'h1);
        @(posedge clk_sys);
        thermistor_below_ref <= 1'b0;
        cyc(PER);
        check_eq("ovt_clr", 16'(ext_overtemp), 16'h0);
        i_pmtsc_host_model.wr(pmtsc_pkg::FEAT_ADDR, 8'h80);
        chk_rd("feat_wr", pmtsc_pkg::FEAT_ADDR, 8'h80);
        count_on(2 * PER);
        check_eq("auto_off", 16'(cnt), 16'h0);
        for (int i = 0; i < 16; i++) begin
            i_pmtsc_host_model.wr(pmtsc_pkg::MSEL_ADDR, 8'(i));
            cyc(3);
            check_eq("route", 16'(monitor_route), 16'(exp_route(i)));
            check_eq("low_pwr", 16'(monitor_low_power), 16'(exp_route(i) == 4'h0));
            check_eq("route_th", 16'(route_thermistor), 16'(i == 8));
            chk_rd("msel", pmtsc_pkg::MSEL_ADDR, 8'(i));
        end
        i_pmtsc_host_model.wr(pmtsc_pkg::MSEL_ADDR, 8'(pmtsc_pkg::MSEL_EXT));
        @(posedge clk_sys);
        thermistor_below_ref <= 1'b1;
        cyc(3);
        count_on(300);
        check_eq("sel_on", 16'(cnt), 16'd300);
        check_eq("sel_ovt", 16'(ext_overtemp), 16'h1);
        @(posedge clk_sys);
        thermistor_below_ref <= 1'b0;
        i_pmtsc_host_model.wr(pmtsc_pkg::FEAT_ADDR, 8'h00);
        count_on(300);
        check_eq("both_on", 16'(cnt), 16'd300);
        i_pmtsc_host_model.wr(pmtsc_pkg::MSEL_ADDR, 8'(pmtsc_pkg::MSEL_CELL1));
        i_pmtsc_host_model.wr(pmtsc_pkg::FEAT_ADDR, 8'ha0);
        cyc(3);
        count_on(300);
        check_eq("force_on", 16'(cnt), 16'd300);
        chk_rd("status", pmtsc_pkg::STAT_ADDR, 8'h0e);
        i_pmtsc_host_model.wr(pmtsc_pkg::WREN_ADDR, flags);
        i_pmtsc_host_model.wr(pmtsc_pkg::FEAT_ADDR, 8'h01);
        chk_rd("feat_relock", pmtsc_pkg::FEAT_ADDR, 8'ha0);
        for (int k = 0; k < 2; k++) begin
            pol = k[0];
            i_pmtsc_host_model.wr(pmtsc_pkg::WREN_ADDR, 8'h80 | flags);
            i_pmtsc_host_model.wr(pmtsc_pkg::FEAT_ADDR, {7'h00, pol});
            @(posedge clk_sys);
            wake_pin <= pol;
            i_pmtsc_host_model.wr(pmtsc_pkg::CTRL_ADDR, 8'h80);
            cyc(4);
            check_eq("asleep", 16'(regulated_supply_out), 16'h0);
            check_eq("sleep_sens", 16'(sensor_supply_out), 16'h0);
            @(posedge clk_sys);
            wake_pin <= ~pol;
            cyc(4);
            check_eq("no_wake", 16'(regulated_supply_out), 16'h0);
            @(posedge clk_sys);
            wake_pin <= pol;
            cyc(4);
            check_eq("woke", 16'(regulated_supply_out), 16'h1);
            chk_rd("sleep_clr", pmtsc_pkg::CTRL_ADDR, 8'h00);
            chk_rd("msel_kept", pmtsc_pkg::MSEL_ADDR, 8'(pmtsc_pkg::MSEL_CELL1));
            chk_rd("flags_kept", pmtsc_pkg::WREN_ADDR, 8'h80 | flags);
        end
        @(posedge clk_sys);
        por_ok_taps <= 3'($urandom_range(0, 6));
        cyc(3);
        check_eq("por_loss", 16'(regulated_supply_out), 16'h0);
        @(posedge clk_sys);
        por_ok_taps <= 3'h7;
        cyc(3);
        check_eq("por_back", 16'(regulated_supply_out), 16'h1);
        chk_rd("flags_por", pmtsc_pkg::WREN_ADDR, 8'h80 | flags);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        cyc(2);
        check_eq("reg_on2", 16'(regulated_supply_out), 16'h1);
        chk_rd("wren_rst2", pmtsc_pkg::WREN_ADDR, 8'h00);
        tally_and_finish();
    end
endmodule : tb_pmtsc_top
`default_nettype wire
